//--- inc/spcf_map.vh
// Constants of the serial configuration port: offsets, fields, timing.
`ifndef SPCF_MAP_VH
`define SPCF_MAP_VH
`define SPCF_APB_ADDR_W     16
`define SPCF_APB_DATA_W     32
`define SPCF_OFS_TXDATA     16'h0000
`define SPCF_OFS_RXDATA     16'h0004
`define SPCF_OFS_STATUS     16'h0008
`define SPCF_ST_TX_EMPTY    0
`define SPCF_ST_TX_FULL     1
`define SPCF_ST_RX_EMPTY    2
`define SPCF_ST_RX_FULL     3
`define SPCF_ST_BUSY        4
`define SPCF_FRAME_BITS     16
`define SPCF_FIFO_DEPTH     32
`define SPCF_DIV_W          8
`define SPCF_DIV_RESET      8'h07
`define SPCF_PCLK_HZ        80000000
`define SPCF_ZERO_WORD      32'h0000_0000
`endif

//--- test/spcf_target_model.sv
// Behavioural serial target answering at the far end of the link.
module spcf_target_model (
    input  wire  sclk,
    input  wire  select_n,
    input  wire  mosi,
    output logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] shift_in  = 16'h0000;
    logic [15:0] shift_out = 16'h0000;
    logic [15:0] got_q[$];
    int          bitn   = 0;
    int          frames = 0;
    int          pulses = 0;
    initial miso = 1'b1;
    function automatic logic [15:0] resp(input int n);
        return 16'hA5C3 ^ {n[7:0], n[7:0]};
    endfunction
    always @(negedge select_n) begin
        pulses++;
        bitn = 0;
        shift_out = resp(frames);
        miso = shift_out[15];
    end
    // A released line shows the inverse of its last bit, never a stale one.
    always @(posedge select_n) miso = ~miso;
    always @(posedge sclk) begin
        if (!select_n) begin
            shift_in = {shift_in[14:0], mosi};
            bitn++;
            if (bitn == 16) begin
                got_q.push_back(shift_in);
                frames++;
                bitn = 0;
                shift_out = resp(frames);
            end
        end
    end
    always @(negedge sclk) begin
        if (!select_n) miso = shift_out[15 - bitn];
    end
endmodule

//--- test/spcf_top_chk.sv
// Port assertions for the serial configuration port.
module spcf_top_chk (
    input logic        core_clk,
    input logic        resetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        enable,
    input logic [7:0]  clock_divider,
    input logic        busy,
    input logic        serial_clock_out,
    input logic        select_n,
    input logic        data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]  prev_reg;
    logic [7:0]  len_reg;
    logic [15:0] rise_reg;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Cycles since select or serial clock last moved, and rises per select.
    always @(posedge core_clk) begin
        if (!resetn) begin
            prev_reg <= 2'b10;
            len_reg  <= 8'h00;
            rise_reg <= 16'h0000;
        end else begin
            prev_reg <= {select_n, serial_clock_out};
            if ({select_n, serial_clock_out} != prev_reg)
                len_reg <= 8'h00;
            else
                len_reg <= len_reg + 8'h01;
            if (select_n)
                rise_reg <= 16'h0000;
            else if (serial_clock_out && !prev_reg[0])
                rise_reg <= rise_reg + 16'h0001;
        end
    end
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_in_bus: assert property (pslverr |-> psel || $past(psel))
        else $error("pslverr outside transfer");
    a_upper_zero: assert property (psel && penable && !pwrite
        |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
    a_half_period: assert property (!select_n
        && serial_clock_out != prev_reg[0] |-> len_reg == clock_divider)
        else $error("half period wrong");
    a_idle_low: assert property (select_n |-> !serial_clock_out)
        else $error("clock not idle low");
    a_whole_frames: assert property ($rose(select_n)
        |-> rise_reg[3:0] == 4'h0 && rise_reg != 16'h0000)
        else $error("partial frame");
    a_start_enabled: assert property ($fell(select_n) |-> $past(enable))
        else $error("frame started while disabled");
    a_data_on_fall: assert property (!select_n && $changed(data_out)
        |-> $fell(serial_clock_out) || $fell(select_n))
        else $error("data out moved off falling edge");
    a_busy_frame: assert property (!select_n |-> busy)
        else $error("not busy in frame");
endmodule
bind spcf_top spcf_top_chk u_chk (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable(enable), .busy(busy),
    .clock_divider(clock_divider), .serial_clock_out(serial_clock_out),
    .select_n(select_n), .data_out(data_out));

//--- test/tb_spcf_top.sv
// Self-checking bench for the serial configuration port.
module tb_spcf_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, resetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, enable = 0, hold_select = 0, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0]  clock_divider = 8'h07;
    logic        pready, pslverr, busy, serial_clock_out, select_n;
    logic        data_out, data_in;
    logic [15:0] sent[$];
    int          err_count = 0, n_tests = 0, i, r, np = 0, nf = 0;
    spcf_top uut (.core_clk(core_clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enable(enable), .hold_select(hold_select), .busy(busy),
        .clock_divider(clock_divider), .serial_clock_out(serial_clock_out),
        .select_n(select_n), .data_out(data_out), .data_in(data_in));
    spcf_target_model peer (.sclk(serial_clock_out), .select_n(select_n),
        .mosi(data_out), .miso(data_in));
    initial forever #10 core_clk = ~core_clk;
    function automatic logic [15:0] resp(input int n);
        return 16'hA5C3 ^ {n[7:0], n[7:0]};
    endfunction
    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One transfer; the answer is taken at the edge that sees pready high.
    task automatic apb(input logic [15:0] a, input logic w, logic [31:0] d);
        int k;
        @(posedge core_clk);
        #2;
        psel = 1'b1;
        paddr = a;
        pwrite = w;
        pwdata = d;
        @(posedge core_clk);
        #2;
        penable = 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        #2;
        psel = 1'b0;
        penable = 1'b0;
        if (k == 16) begin
            err_count++;
            $display("unexpected %0t pready never high", $time);
            stop_test;
        end
    endtask
    task automatic wr(input logic [15:0] a, logic [31:0] d, logic e);
        apb(a, 1'b1, d);
        check({31'h0, err}, {31'h0, e}, "write refusal");
    endtask
    task automatic rdc(input logic [15:0] a, logic [31:0] x, logic e);
        apb(a, 1'b0, 32'h0000_0000);
        check({31'h0, err}, {31'h0, e}, "read refusal");
        if (!e) check(rd, x, "read data");
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 6000; k++) begin
            apb(16'h0008, 1'b0, 32'h0000_0000);
            if (rd[0] === 1'b1 && rd[4] === 1'b0) return;
        end
        err_count++;
        $display("unexpected %0t engine never idle", $time);
        stop_test;
    endtask
    initial begin
        i = $urandom(13);
        repeat (16) @(posedge core_clk);
        #2 resetn = 1'b1;
        rdc(16'h0008, 32'h0000_0005, 1'b0);
        rdc(16'h0004, 32'h0000_0000, 1'b1);
        wr(16'h0008, 32'h0000_0001, 1'b1);
        rdc(16'h000C, 32'h0000_0000, 1'b1);
        $display("test registers done");
        for (i = 0; i < 32; i++) begin
            sent.push_back(16'($urandom));
            wr(16'h0000, {16'hFFFF, sent[i]}, 1'b0);
        end
        rdc(16'h0008, 32'h0000_0006, 1'b0);
        wr(16'h0000, 32'h0000_0000, 1'b1);
        enable = 1'b1;
        wait_idle;
        rdc(16'h0008, 32'h0000_0009, 1'b0);
        sent.push_back(16'h8001);
        wr(16'h0000, 32'h0000_8001, 1'b0);
        repeat (100) @(posedge core_clk);
        rdc(16'h0008, 32'h0000_0008, 1'b0);
        for (i = 0; i < 32; i++) rdc(16'h0004, {16'h0, resp(i)}, 1'b0);
        wait_idle;
        rdc(16'h0004, {16'h0, resp(32)}, 1'b0);
        np = 33;
        nf = 33;
        $display("test fill and drain done");
        for (r = 0; r < 2; r++) begin
            hold_select = r[0];
            clock_divider = r ? 8'($urandom_range(1, 3)) : 8'h00;
            for (i = 0; i < 4; i++) begin
                sent.push_back(16'($urandom));
                wr(16'h0000, {16'h0, sent[nf + i]}, 1'b0);
            end
            wait_idle;
            np += r ? 1 : 4;
            check(peer.pulses, np, "select pulses");
            for (i = 0; i < 4; i++) rdc(16'h0004, {16'h0, resp(nf + i)}, 1'b0);
            nf += 4;
            $display("test round %0d done", r);
        end
        check(peer.got_q.size(), sent.size(), "frame count");
        for (i = 0; i < sent.size(); i++) check(peer.got_q[i], sent[i], "frame");
        stop_test;
    end
endmodule

//--- verilog/spcf_fifo.v
// Synchronous FIFO with a registered read-data word.
module spcf_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             core_clk,
    input  wire             resetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             full,
    output wire             empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    reg [WIDTH-1:0] data_reg;
    wire            do_wr;
    wire            do_rd;
    wire [AW-1:0]   rd_ptr_next;

    assign full      = (count_reg == DEPTH[AW:0]);
    assign empty     = (count_reg == {(AW+1){1'b0}});
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = data_reg;
    assign do_wr     = in_valid & ~full;
    assign do_rd     = out_ready & ~empty;
    assign rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

    always @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // The head word is refreshed every cycle; a write into the head slot
    // is forwarded so that a word pushed into an empty FIFO shows at once.
    always @(posedge core_clk) begin
        if (!resetn) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            data_reg   <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            rd_ptr_reg <= rd_ptr_next;
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
            if (do_wr && wr_ptr_reg == rd_ptr_next) begin
                data_reg <= in_data;
            end else begin
                data_reg <= mem[rd_ptr_next];
            end
        end
    end
endmodule

//--- verilog/spcf_top.v
// Serial configuration port: APB target, frame FIFOs and serial engine.
// Notes on behaviour
// [RULE1] Register port is a 32-bit APB target returning full 32-bit words; the code returns sixteen data bits with the upper half zero.
// [RULE2] Serial link uses four wires: clock, select, data out, data in.
// [RULE3] Every serial frame is exactly sixteen bits long.
// [RULE4] Transmit and receive buffers each hold thirty-two frames.
// [RULE5] Serial clock equals bus clock over twice the divider plus one.
// [RULE6] With hold-select on, select stays active across back-to-back frames.
// [RULE7] The block runs on the eighty megahertz peripheral bus clock.
// [RULE8] The interconnect presents only a sixteen-bit offset to this slot.
// [RULE9] This block sits in the third slot at its fixed base address.
// [RULE10] Frames go most significant bit first, clock idle low, mode zero.
`include "spcf_map.vh"
module spcf_top #(
    parameter FRAME_BITS = `SPCF_FRAME_BITS,
    parameter FIFO_DEPTH = `SPCF_FIFO_DEPTH,
    parameter FIFO_AW    = 5,
    parameter PCLK_HZ    = `SPCF_PCLK_HZ // RULE7
) (
    input  wire                          core_clk,
    input  wire                          resetn,
    input  wire [`SPCF_APB_ADDR_W-1:0]   paddr,
    input  wire                          psel,
    input  wire                          penable,
    input  wire                          pwrite,
    input  wire [`SPCF_APB_DATA_W-1:0]   pwdata,
    output wire [`SPCF_APB_DATA_W-1:0]   prdata,
    output wire                          pready,
    output wire                          pslverr,
    input  wire                          enable,
    input  wire                          hold_select,
    input  wire [`SPCF_DIV_W-1:0]        clock_divider,
    output wire                          busy,
    output wire                          serial_clock_out,
    output wire                          select_n,
    output wire                          data_out,
    input  wire                          data_in
);
    // ==========================================================
    // APB target
    // ==========================================================
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_XFER = 2'b01;
    localparam [1:0] ST_GAP  = 2'b10;

    wire                  setup_ph;
    wire                  access_ph;
    wire                  hit_tx;
    wire                  hit_rx;
    wire                  hit_st;
    wire                  tx_in_ready;
    wire                  tx_valid;
    wire [FRAME_BITS-1:0] tx_data;
    wire                  tx_full;
    wire                  tx_empty;
    wire                  rx_in_ready;
    wire                  rx_valid;
    wire [FRAME_BITS-1:0] rx_data;
    wire                  rx_full;
    wire                  rx_empty;
    wire                  tx_pop;
    wire                  rx_push;
    reg  [`SPCF_APB_DATA_W-1:0] prdata_reg;
    reg                   pslverr_reg;
    reg  [`SPCF_APB_DATA_W-1:0] rd_word;
    reg                   bad_access;
    wire                  tx_push;
    wire                  rx_pop;

    reg [1:0]             state_reg;
    reg [`SPCF_DIV_W-1:0] div_cnt_reg;
    reg                   sclk_reg;
    reg                   sel_n_reg;
    reg                   mosi_reg;
    reg [FRAME_BITS-1:0]  shift_reg;
    reg [4:0]             bit_cnt_reg;
    reg [FIFO_AW:0]       rx_level_reg;
    wire                  half_tick;
    wire                  can_start;
    wire                  last_fall;
    wire                  rx_room2;
    wire                  start_idle;
    wire                  start_next;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_tx    = (paddr == `SPCF_OFS_TXDATA); // RULE8
    assign hit_rx    = (paddr == `SPCF_OFS_RXDATA); // RULE8
    assign hit_st    = (paddr == `SPCF_OFS_STATUS); // RULE8
    assign pready    = 1'b1;
    assign prdata    = prdata_reg;
    assign pslverr   = pslverr_reg;
    assign tx_push   = access_ph & pwrite & hit_tx & ~pslverr_reg; // RULE4
    assign rx_pop    = access_ph & ~pwrite & hit_rx & ~pslverr_reg; // RULE4

    // Read data and error are decided in the setup phase so that both come
    // from flip-flops during the access phase.
    always @* begin
        rd_word    = `SPCF_ZERO_WORD;
        bad_access = 1'b0;
        if (hit_rx && !pwrite) begin
            rd_word[FRAME_BITS-1:0] = rx_data; // RULE1
            bad_access = ~rx_valid;
        end else if (hit_st && !pwrite) begin
            rd_word[`SPCF_ST_TX_EMPTY] = tx_empty;
            rd_word[`SPCF_ST_TX_FULL]  = tx_full;
            rd_word[`SPCF_ST_RX_EMPTY] = rx_empty;
            rd_word[`SPCF_ST_RX_FULL]  = rx_full;
            rd_word[`SPCF_ST_BUSY]     = busy;
        end else if (hit_tx && pwrite) begin
            bad_access = ~tx_in_ready;
        end else begin
            bad_access = 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            prdata_reg  <= `SPCF_ZERO_WORD;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg  <= rd_word; // RULE1
            pslverr_reg <= bad_access;
        end else if (!psel) begin
            pslverr_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Frame buffers
    // ==========================================================
    spcf_fifo #(
        .WIDTH (FRAME_BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_tx_fifo ( // RULE4
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (pwdata[FRAME_BITS-1:0]),
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .out_data  (tx_data),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    spcf_fifo #(
        .WIDTH (FRAME_BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo ( // RULE4
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (shift_reg),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_data),
        .full      (rx_full),
        .empty     (rx_empty)
    );

    // ==========================================================
    // Serial engine
    // ==========================================================
    assign half_tick = (div_cnt_reg == clock_divider); // RULE5
    // A frame starts only when the receive side has a slot for its word,
    // so a full receive buffer stalls the link instead of losing a frame.
    // A frame chained under hold-select is decided before the current word
    // is pushed, so it needs room for both words.
    assign can_start = enable & tx_valid;
    assign rx_room2  = (rx_level_reg + 2'd2 <= FIFO_DEPTH[FIFO_AW:0]);
    assign last_fall = sclk_reg & half_tick &
                       (bit_cnt_reg == FRAME_BITS[4:0] - 5'd1); // RULE3
    assign start_idle = (state_reg == ST_IDLE) & can_start & rx_in_ready;
    assign start_next = (state_reg == ST_XFER) & last_fall & can_start &
                        hold_select & rx_room2; // RULE6
    assign tx_pop    = start_idle | start_next;
    // The finished word is pushed at the last falling edge, in the same
    // cycle in which a chained frame reloads the shift register.
    assign rx_push   = (state_reg == ST_XFER) & last_fall; // RULE3
    assign busy      = (state_reg != ST_IDLE);
    assign serial_clock_out = sclk_reg; // RULE2
    assign select_n  = sel_n_reg; // RULE2
    assign data_out  = mosi_reg; // RULE2

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_reg   <= ST_IDLE;
            div_cnt_reg <= {`SPCF_DIV_W{1'b0}};
            sclk_reg    <= 1'b0;
            sel_n_reg   <= 1'b1;
            mosi_reg    <= 1'b0;
            shift_reg   <= {FRAME_BITS{1'b0}};
            bit_cnt_reg <= 5'd0;
        end else begin
            if (state_reg == ST_IDLE || half_tick) begin
                div_cnt_reg <= {`SPCF_DIV_W{1'b0}};
            end else begin
                div_cnt_reg <= div_cnt_reg + 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    sclk_reg <= 1'b0; // RULE10
                    if (tx_pop) begin
                        state_reg   <= ST_XFER;
                        sel_n_reg   <= 1'b0;
                        mosi_reg    <= tx_data[FRAME_BITS-1]; // RULE10
                        shift_reg   <= {tx_data[FRAME_BITS-2:0], 1'b0};
                        bit_cnt_reg <= 5'd0;
                    end
                end
                ST_XFER: begin
                    if (half_tick) begin
                        sclk_reg <= ~sclk_reg; // RULE5
                        if (!sclk_reg) begin
                            // Rising edge: sample the target's bit.
                            shift_reg[0] <= data_in; // RULE10
                        end else if (last_fall) begin
                            if (tx_pop) begin
                                mosi_reg    <= tx_data[FRAME_BITS-1];
                                shift_reg   <= {tx_data[FRAME_BITS-2:0],
                                                1'b0};
                                bit_cnt_reg <= 5'd0;
                            end else begin
                                state_reg <= ST_GAP;
                                sel_n_reg <= 1'b1;
                            end
                        end else begin
                            // Falling edge: launch the next bit.
                            mosi_reg    <= shift_reg[FRAME_BITS-1]; // RULE10
                            shift_reg   <= {shift_reg[FRAME_BITS-2:0],
                                            1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 5'd1;
                        end
                    end
                end
                ST_GAP: begin
                    // Select stays released for one half period.
                    if (half_tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    sel_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Receive occupancy
    // ==========================================================
    // Mirrors the receive buffer's count so that a chained frame is
    // refused while only one slot is left.
    always @(posedge core_clk) begin
        if (!resetn) begin
            rx_level_reg <= {(FIFO_AW+1){1'b0}};
        end else if (rx_push && rx_in_ready && !(rx_pop && rx_valid)) begin
            rx_level_reg <= rx_level_reg + 1'b1; // RULE4
        end else if (rx_pop && rx_valid && !(rx_push && rx_in_ready)) begin
            rx_level_reg <= rx_level_reg - 1'b1; // RULE4
        end
    end
endmodule
